/* File: common/opc_pkg.sv */
// constants and types shared by the output pair control register bank
package opc_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] OPC_IDX_OUT_TWO = 8'h22;
  localparam logic [7:0] OPC_IDX_OUT_THREE = 8'h23;
  localparam logic [7:0] OPC_IDX_STATUS = 8'h2f;
  // field positions inside the channel registers; the source bit is in output two only
  localparam int OPC_SRC_BIT = 7;
  localparam int OPC_FMT_LO = 5;
  localparam int OPC_MODEA_LO = 3;
  localparam int OPC_MODEB_LO = 1;
  // values after reset and writable masks (reserved bits clear)
  localparam logic [7:0] OPC_RST_OUT_TWO = 8'hb0;
  localparam logic [7:0] OPC_RST_OUT_THREE = 8'h30;
  localparam logic [7:0] OPC_MASK_OUT_TWO = 8'hfe;
  localparam logic [7:0] OPC_MASK_OUT_THREE = 8'h7e;
  // status register bit positions
  localparam int OPC_STAT_TWO_ON = 0;
  localparam int OPC_STAT_THREE_ON = 1;
  localparam int OPC_STAT_NV_LOADED = 2;
  // driver format codes
  typedef enum logic [1:0] {
    OPC_FMT_OFF,
    OPC_FMT_DIFF,
    OPC_FMT_HCSL,
    OPC_FMT_CMOS
  } opc_fmt_t;
  // tail currents in mA for mode a codes 0..3
  localparam logic [4:0] OPC_TAIL_C0 = 5'h04;
  localparam logic [4:0] OPC_TAIL_C1 = 5'h06;
  localparam logic [4:0] OPC_TAIL_C2 = 5'h08;
  localparam logic [4:0] OPC_TAIL_C3_HCSL = 5'h10;
  localparam logic [4:0] OPC_TAIL_C3_AC = 5'h08;
  // hcsl load in ohms for mode b codes 0..3, zero means tri-state
  localparam logic [7:0] OPC_LOAD_C0 = 8'h00;
  localparam logic [7:0] OPC_LOAD_C1 = 8'h32;
  localparam logic [7:0] OPC_LOAD_C2 = 8'h64;
  localparam logic [7:0] OPC_LOAD_C3 = 8'hc8;
endpackage

/* File: dv/opc_regs_test.sv */
// self-checking bench for the output pair control register bank
`timescale 1ns/10ps
module opc_regs_test;
  logic core_clk_i;
  logic reset_i;
  logic psel_i;
  logic penable_i;
  logic pwrite_i;
  logic nv_load_i;
  logic [9:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic [3:0] pstrb_i;
  logic pready_o;
  logic pslverr_o;
  logic sel_o;
  logic [7:0] nv_two_i;
  logic [7:0] nv_three_i;
  logic [1:0][7:0] reg_o;
  logic [1:0] src_o;
  logic [1:0] en_o;
  logic [1:0][4:0] tail_o;
  logic [1:0][7:0] load_o;
  logic [1:0][1:0] pos_o;
  logic [1:0][1:0] neg_o;
  int num_errors;
  int checks;
  int cycles;
  int m [2];
  int nvseen;
  int i;
  int c;
  logic [31:0] d;
  localparam logic [9:0] A2 = {opc_pkg::OPC_IDX_OUT_TWO, 2'b00};
  localparam logic [9:0] A3 = {opc_pkg::OPC_IDX_OUT_THREE, 2'b00};
  localparam logic [9:0] AS = {opc_pkg::OPC_IDX_STATUS, 2'b00};

  opc_regs #(.AW(10)) dut_u (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .nv_load_i(nv_load_i),
    .nv_two_i(nv_two_i), .nv_three_i(nv_three_i),
    .output_two_control_o(reg_o[0]), .output_three_control_o(reg_o[1]),
    .pair_source_select_o(sel_o), .chan_two_source_o(src_o[0]),
    .chan_three_source_o(src_o[1]), .chan_two_enable_o(en_o[0]),
    .chan_three_enable_o(en_o[1]), .chan_two_tail_ma_o(tail_o[0]),
    .chan_three_tail_ma_o(tail_o[1]), .chan_two_load_ohm_o(load_o[0]),
    .chan_three_load_ohm_o(load_o[1]), .chan_two_pos_pin_o(pos_o[0]),
    .chan_three_pos_pin_o(pos_o[1]), .chan_two_neg_pin_o(neg_o[0]),
    .chan_three_neg_pin_o(neg_o[1])
  );

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  task automatic conclude();
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, far above the roughly one thousand cycles the run needs
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // psel stays up so a following call is a back-to-back setup cycle
  task automatic apb(input logic wr, input logic [9:0] a,
                     input logic [31:0] wd, input logic [3:0] s);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    pstrb_i <= s;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    // answer is taken at the rising edge where pready is seen high
    @(posedge core_clk_i);
    while (pready_o !== 1'b1)
      @(posedge core_clk_i);
    d = prdata_o;
    check(pslverr_o, a != A2 && a != A3 && a != AS);
  endtask

  task automatic idle();
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic wreg(input logic [9:0] a, input logic [31:0] wd,
                      input logic [3:0] s);
    apb(1'b1, a, wd, s);
    if (s[0] && a == A2)
      m[0] = wd & opc_pkg::OPC_MASK_OUT_TWO;
    if (s[0] && a == A3)
      m[1] = wd & opc_pkg::OPC_MASK_OUT_THREE;
  endtask

  function automatic int fmt(int k);
    return (m[k] >> 5) & 3;
  endfunction

  task automatic rreg(input logic [9:0] a);
    int e;
    e = (a == A2) ? m[0] : (a == A3) ? m[1] : 0;
    if (a == AS)
      e = (nvseen << 2) | ((fmt(1) != 0) << 1) | (fmt(0) != 0);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    check(d, e);
  endtask

  // expected driver settings: en, src, tail, load, pos, neg
  function automatic int dec(int k);
    int f;
    int a;
    int b;
    int t;
    int l;
    f = fmt(k);
    a = (m[k] >> 3) & 3;
    b = (m[k] >> 1) & 3;
    t = 0;
    l = 0;
    if (f == 1 || f == 2)
      t = (a == 0) ? 4 : (a == 1) ? 6 : (a == 3 && f == 2) ? 16 : 8;
    if (f == 2 && b != 0)
      l = 50 << (b - 1);
    return ((f != 0) << 18) | (((m[0] >> 7) & 1) << 17) | (t << 12) |
           (l << 4) | ((f == 3) ? ((a << 2) | b) : 0);
  endfunction

  task automatic check_all();
    idle();
    @(negedge core_clk_i);
    check(sel_o, m[0] >> 7 & 1);
    for (int k = 0; k < 2; k++) begin
      check(reg_o[k], m[k]);
      check({en_o[k], src_o[k], tail_o[k], load_o[k], pos_o[k], neg_o[k]},
            dec(k));
    end
    @(posedge core_clk_i);
    rreg(A2);
    rreg(A3);
    rreg(AS);
    idle();
  endtask

  task automatic do_reset();
    reset_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b0;
    m[0] = 8'hb0;
    m[1] = 8'h30;
    nvseen = 0;
    @(posedge core_clk_i);
  endtask

  initial begin
    {psel_i, penable_i, pwrite_i, nv_load_i} = 4'h0;
    paddr_i = 10'h000;
    pwdata_i = 32'h0000_0000;
    pstrb_i = 4'h0;
    nv_two_i = 8'h00;
    nv_three_i = 8'h00;
    reset_i = 1'b1;
    void'($urandom(32'h74a594e4));
    do_reset();
    check_all();
    // every format with every mode code, random reserved bits
    for (i = 0; i < 64; i++) begin
      for (c = 0; c < 2; c++) begin
        d = $urandom;
        d[6:1] = (c == 0) ? i[5:0] : ~i[5:0];
        // output two last, so the read below follows its write at once
        wreg(c == 0 ? A3 : A2, d, 4'hf);
      end
      rreg(A2);
      check_all();
    end
    // lane zero off, status write, unmapped and unaligned
    wreg(A2, $urandom, 4'he);
    wreg(AS, $urandom, 4'hf);
    wreg(10'h090, $urandom, 4'hf);
    wreg(A3 + 10'h001, $urandom, 4'hf);
    rreg(10'h090);
    rreg(A2 + 10'h002);
    check_all();
    // nonvolatile image load keeps reserved bits clear
    nv_two_i <= $urandom;
    nv_three_i <= $urandom;
    nv_load_i <= 1'b1;
    @(posedge core_clk_i);
    nv_load_i <= 1'b0;
    m[0] = nv_two_i & opc_pkg::OPC_MASK_OUT_TWO;
    m[1] = nv_three_i & opc_pkg::OPC_MASK_OUT_THREE;
    nvseen = 1;
    check_all();
    do_reset();
    check_all();
    conclude();
  end
endmodule

/* File: rtl/opc_apb_if.sv */
// apb slave front end: decode, strobes and registered answer
`timescale 1ns/10ps
module opc_apb_if #(
  parameter int AW = 10
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic [7:0] rd_two_i,
  input wire logic [7:0] rd_three_i,
  input wire logic [7:0] rd_status_i,
  output logic wr_two_o,
  output logic wr_three_o,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pslverr_q;
  wire aligned = (paddr_i[1:0] == 2'h0);
  wire [AW-3:0] idx = paddr_i[AW-1:2];
  wire hit_two = aligned && (idx == (AW-2)'(opc_pkg::OPC_IDX_OUT_TWO));
  wire hit_three = aligned &&
    (idx == (AW-2)'(opc_pkg::OPC_IDX_OUT_THREE));
  wire hit_stat = aligned && (idx == (AW-2)'(opc_pkg::OPC_IDX_STATUS));
  wire hit_any = hit_two | hit_three | hit_stat;
  wire setup = psel_i & ~penable_i;
  wire done = psel_i & penable_i & pready_q;
  wire [7:0] rd_sel = hit_two ? rd_two_i :
                      hit_three ? rd_three_i :
                      hit_stat ? rd_status_i : 8'h00;

  // answer is prepared in the setup cycle so prdata, pready and pslverr come from flops
  always_comb begin
    prdata_d = 32'h0000_0000;
    if (setup && !pwrite_i) begin
      prdata_d = {24'h00_0000, rd_sel};
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit_any;
      prdata_q <= prdata_d;
    end
  end

  // status is read-only; writes there are dropped without error
  assign wr_two_o = done & pwrite_i & hit_two;
  assign wr_three_o = done & pwrite_i & hit_three;
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
endmodule

/* File: rtl/opc_drv_decode.sv */
// per-channel driver decode: format and mode fields to driver settings
`timescale 1ns/10ps
module opc_drv_decode (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic src_i,
  input wire logic [1:0] fmt_i,
  input wire logic [1:0] mode_a_i,
  input wire logic [1:0] mode_b_i,
  output logic src_o,
  output logic enable_o,
  output logic [4:0] tail_ma_o,
  output logic [7:0] load_ohm_o,
  output logic [1:0] pos_pin_o,
  output logic [1:0] neg_pin_o
);
  logic [4:0] tail_d;
  logic [7:0] load_d;
  opc_pkg::opc_fmt_t fmt;
  assign fmt = opc_pkg::opc_fmt_t'(fmt_i);
  wire is_diff = (fmt == opc_pkg::OPC_FMT_DIFF) ||
                 (fmt == opc_pkg::OPC_FMT_HCSL);
  wire is_hcsl = (fmt == opc_pkg::OPC_FMT_HCSL);
  wire is_cmos = (fmt == opc_pkg::OPC_FMT_CMOS);

  always_comb begin
    tail_d = 5'h00;
    if (is_diff) begin
      unique case (mode_a_i)
        2'h0: tail_d = opc_pkg::OPC_TAIL_C0;
        2'h1: tail_d = opc_pkg::OPC_TAIL_C1;
        2'h2: tail_d = opc_pkg::OPC_TAIL_C2;
        2'h3: tail_d = is_hcsl ? opc_pkg::OPC_TAIL_C3_HCSL
                               : opc_pkg::OPC_TAIL_C3_AC;
      endcase
    end
  end

  always_comb begin
    load_d = opc_pkg::OPC_LOAD_C0;
    if (is_hcsl) begin
      unique case (mode_b_i)
        2'h0: load_d = opc_pkg::OPC_LOAD_C0;
        2'h1: load_d = opc_pkg::OPC_LOAD_C1;
        2'h2: load_d = opc_pkg::OPC_LOAD_C2;
        2'h3: load_d = opc_pkg::OPC_LOAD_C3;
      endcase
    end
  end

  // outside cmos both pins read as powered down, tri-stated
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      src_o <= 1'b0;
      enable_o <= 1'b0;
      tail_ma_o <= 5'h00;
      load_ohm_o <= 8'h00;
      pos_pin_o <= 2'h0;
      neg_pin_o <= 2'h0;
    end else begin
      src_o <= src_i;
      enable_o <= (fmt != opc_pkg::OPC_FMT_OFF);
      tail_ma_o <= tail_d;
      load_ohm_o <= load_d;
      pos_pin_o <= is_cmos ? mode_a_i : 2'h0;
      neg_pin_o <= is_cmos ? mode_b_i : 2'h0;
    end
  end
endmodule

/* File: rtl/opc_regs.sv */
// output pair control registers for clock channels two and three
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
module opc_regs #(
  parameter int AW = 10
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic nv_load_i,
  input wire logic [7:0] nv_two_i,
  input wire logic [7:0] nv_three_i,
  output logic [7:0] output_two_control_o,
  output logic [7:0] output_three_control_o,
  output logic pair_source_select_o,
  output logic chan_two_source_o,
  output logic chan_three_source_o,
  output logic chan_two_enable_o,
  output logic chan_three_enable_o,
  output logic [4:0] chan_two_tail_ma_o,
  output logic [4:0] chan_three_tail_ma_o,
  output logic [7:0] chan_two_load_ohm_o,
  output logic [7:0] chan_three_load_ohm_o,
  output logic [1:0] chan_two_pos_pin_o,
  output logic [1:0] chan_three_pos_pin_o,
  output logic [1:0] chan_two_neg_pin_o,
  output logic [1:0] chan_three_neg_pin_o
);
  logic [7:0] two_q, two_d, three_q, three_d;
  logic nv_loaded_q;
  logic wr_two, wr_three;
  logic [7:0] status;
  logic [1:0] ch_src, ch_en;
  logic [4:0] ch_tail [2];
  logic [7:0] ch_load [2];
  logic [1:0] ch_pos [2];
  logic [1:0] ch_neg [2];
  logic [7:0] ch_reg [2];

  opc_apb_if #(
    .AW(AW)
  ) u_apb (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .rd_two_i(two_q),
    .rd_three_i(three_q),
    .rd_status_i(status),
    .wr_two_o(wr_two),
    .wr_three_o(wr_three),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o)
  );

  // only byte lane 0 carries register data; other lanes are ignored
  wire lane0 = pstrb_i[0];
  wire [7:0] wdata = pwdata_i[7:0];
  wire [7:0] two_wr_val = wdata & opc_pkg::OPC_MASK_OUT_TWO;
  wire [7:0] three_wr_val = wdata & opc_pkg::OPC_MASK_OUT_THREE;
  wire [7:0] two_nv_val = nv_two_i & opc_pkg::OPC_MASK_OUT_TWO;
  wire [7:0] three_nv_val = nv_three_i & opc_pkg::OPC_MASK_OUT_THREE;

  // a bus write in the same cycle as a nonvolatile load wins
  assign two_d = (wr_two && lane0) ? two_wr_val :
                 nv_load_i ? two_nv_val : two_q;
  assign three_d = (wr_three && lane0) ? three_wr_val :
                   nv_load_i ? three_nv_val : three_q;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      two_q <= opc_pkg::OPC_RST_OUT_TWO;
      three_q <= opc_pkg::OPC_RST_OUT_THREE;
      nv_loaded_q <= 1'b0;
    end else begin
      two_q <= two_d;
      three_q <= three_d;
      nv_loaded_q <= nv_loaded_q | nv_load_i;
    end
  end

  assign status = {5'h00, nv_loaded_q,
                   chan_three_enable_o, chan_two_enable_o};

  // both channels take their source from the output-two register
  assign ch_reg[0] = two_q;
  assign ch_reg[1] = three_q;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    opc_drv_decode u_dec (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .src_i(two_q[opc_pkg::OPC_SRC_BIT]),
      .fmt_i(ch_reg[ch][opc_pkg::OPC_FMT_LO +: 2]),
      .mode_a_i(ch_reg[ch][opc_pkg::OPC_MODEA_LO +: 2]),
      .mode_b_i(ch_reg[ch][opc_pkg::OPC_MODEB_LO +: 2]),
      .src_o(ch_src[ch]),
      .enable_o(ch_en[ch]),
      .tail_ma_o(ch_tail[ch]),
      .load_ohm_o(ch_load[ch]),
      .pos_pin_o(ch_pos[ch]),
      .neg_pin_o(ch_neg[ch])
    );
  end

  assign output_two_control_o = two_q;
  assign output_three_control_o = three_q;
  assign pair_source_select_o = two_q[opc_pkg::OPC_SRC_BIT];
  assign chan_two_source_o = ch_src[0];
  assign chan_three_source_o = ch_src[1];
  assign chan_two_enable_o = ch_en[0];
  assign chan_three_enable_o = ch_en[1];
  assign chan_two_tail_ma_o = ch_tail[0];
  assign chan_three_tail_ma_o = ch_tail[1];
  assign chan_two_load_ohm_o = ch_load[0];
  assign chan_three_load_ohm_o = ch_load[1];
  assign chan_two_pos_pin_o = ch_pos[0];
  assign chan_three_pos_pin_o = ch_pos[1];
  assign chan_two_neg_pin_o = ch_neg[0];
  assign chan_three_neg_pin_o = ch_neg[1];

  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  wire acc_wr_two = psel_i && penable_i && pready_o && pwrite_i && lane0
    && (paddr_i == AW'({opc_pkg::OPC_IDX_OUT_TWO, 2'h0}));
  wire acc_wr_three = psel_i && penable_i && pready_o && pwrite_i && lane0
    && (paddr_i == AW'({opc_pkg::OPC_IDX_OUT_THREE, 2'h0}));
  wire setup_rd_two = psel_i && !penable_i && !pwrite_i
    && (paddr_i == AW'({opc_pkg::OPC_IDX_OUT_TWO, 2'h0}));
  wire setup_rd_three = psel_i && !penable_i && !pwrite_i
    && (paddr_i == AW'({opc_pkg::OPC_IDX_OUT_THREE, 2'h0}));

  sequence s_rd_two;
    setup_rd_two && !nv_load_i ##1 psel_i && penable_i;
  endsequence
  sequence s_rd_three;
    setup_rd_three ##1 psel_i && penable_i;
  endsequence

  AST_SRC_WRITE: assert property (
    acc_wr_two |=> pair_source_select_o == $past(pwdata_i[7])
      ##1 chan_two_source_o == pair_source_select_o)
    else $error("source select did not follow write");
  AST_FMT_TWO: assert property (
    acc_wr_two |=> two_q[6:5] == $past(pwdata_i[6:5])
      ##1 chan_two_enable_o == ($past(two_q[6:5]) != 2'h0))
    else $error("channel two format not applied");
  AST_FMT_THREE: assert property (
    acc_wr_three |=> three_q[6:5] == $past(pwdata_i[6:5]))
    else $error("channel three format not applied");
  AST_TAIL_HCSL: assert property (
    (two_q[6:3] == 4'hb) |=> chan_two_tail_ma_o == 5'h10)
    else $error("hcsl tail current wrong");
  AST_TAIL_AC: assert property (
    (three_q[6:5] == 2'h1) && (three_q[4:3] == 2'h0)
      |=> chan_three_tail_ma_o == 5'h04)
    else $error("differential tail current wrong");
  AST_CMOS_PINS: assert property (
    (two_q[6:5] == 2'h3) |=> chan_two_pos_pin_o == $past(two_q[4:3])
      && chan_two_neg_pin_o == $past(two_q[2:1]))
    else $error("cmos pin modes not passed through");
  AST_LOAD: assert property (
    (three_q[6:5] == 2'h2) && (three_q[2:1] == 2'h2)
      |=> chan_three_load_ohm_o == 8'h64)
    else $error("hcsl load wrong");
  AST_RSVD_TWO: assert property (
    s_rd_two |-> prdata_o[0] == 1'b0 && pready_o)
    else $error("reserved bit of output two reads one");
  AST_THREE_SRC: assert property (
    $changed(pair_source_select_o)
      |-> ##1 chan_three_source_o == chan_two_source_o
      && chan_three_source_o == $past(pair_source_select_o))
    else $error("channel three source not shared");
  AST_RSVD_THREE: assert property (
    s_rd_three |-> prdata_o[7] == 1'b0 && prdata_o[0] == 1'b0)
    else $error("reserved bits of output three read one");
  AST_READBACK: assert property (
    acc_wr_two ##1 s_rd_two
      |-> prdata_o[7:0] == ($past(pwdata_i[7:0], 2) & 8'hfe))
    else $error("output two readback mismatch");
endmodule
